// >>> psig_assertions.sv
// Port checker for the mode sequencer.
// Assumes the bench runs FLASH_CYCLES at 4.
`timescale 1ns/1ps
`default_nettype none
module psig_assertions (
   // Clock, reset and watched outputs
   input wire logic       CLK_I,
   input wire logic       SRST_I,
   input wire logic [2:0] SCREEN_O,
   input wire logic       RELAY_O,
   input wire logic       LED_O,
   input wire logic [7:0] LOOP_LEVEL_O,
   input wire logic       BASELINE_START_O
);
   // -------------------------
   // Properties
   // -------------------------
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SRST_I);
   // A flash is a burst of four cycles, then dark
   sequence s_flash;
      LED_O [*4] ##1 !LED_O;
   endsequence
   a_splash_first: assert property ($fell(SRST_I) |-> SCREEN_O == 3'h1)
      else $error("splash missing after reset");
   a_screen_steps: assert property (!$past(SRST_I) && $changed(SCREEN_O)
      && $past(SCREEN_O) inside {3'h1, 3'h2, 3'h3} |-> SCREEN_O == $past(SCREEN_O) + 3'h1)
      else $error("power-on screens out of order");
   a_listen_idle: assert property (SCREEN_O == 3'h0 |-> !RELAY_O)
      else $error("relay set while listening");
   a_relay_detect: assert property (RELAY_O |-> SCREEN_O == 3'h6)
      else $error("relay set outside detection");
   a_detect_entry: assert property ($rose(SCREEN_O == 3'h6) |-> $past(SCREEN_O) == 3'h5)
      else $error("detection without approach");
   a_loop_bounds: assert property (LOOP_LEVEL_O inside {[8'h28:8'hc8]})
      else $error("loop level out of range");
   a_flash_len: assert property ($rose(LED_O) |-> s_flash)
      else $error("flash length wrong");
   a_start_pulse: assert property (BASELINE_START_O |-> ##[0:2] SCREEN_O == 3'h4)
      else $error("baseline start without baseline screen");
endmodule
bind psig_mode_seq psig_assertions u_chk (.*);
`default_nettype wire

// >>> psig_defines.vh
// Constants for the operating-mode sequencer: register offsets, field
// positions, reset values and timing counts.
// Assumes a 100 MHz system clock and a byte-addressed 32-bit register port.
`ifndef PSIG_DEFINES_VH
`define PSIG_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define PSIG_OFF_CTRL      8'h00
`define PSIG_OFF_STATUS    8'h04
`define PSIG_OFF_HOLD      8'h08
`define PSIG_OFF_UPPER     8'h0c
`define PSIG_OFF_LOWER     8'h10
`define PSIG_OFF_EXCUR     8'h14
`define PSIG_OFF_LOOP      8'h18
`define PSIG_OFF_SLAVE     8'h1c
`define PSIG_OFF_TIME      8'h20
`define PSIG_OFF_EVCNT     8'h24
`define PSIG_OFF_EVIDX     8'h28
`define PSIG_OFF_EVDATA    8'h2c
`define PSIG_OFF_IRQ_STAT  8'h30
`define PSIG_OFF_IRQ_MASK  8'h34
`define PSIG_OFF_VERSION   8'h38

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define PSIG_CTRL_DET_RST  0
`define PSIG_IRQ_DETECT    0
`define PSIG_IRQ_APPROACH  1
`define PSIG_IRQ_CANCEL    2
`define PSIG_IRQ_BASELINE  3
`define PSIG_IRQ_LOGFULL   4
`define PSIG_RST_HOLD      24'h00000a
`define PSIG_RST_UPPER     16'h0100
`define PSIG_RST_LOWER     16'h0080
`define PSIG_RST_EXCUR     8'h02
`define PSIG_LOOP_MIN      8'h28
`define PSIG_LOOP_MAX      8'hc8
`define PSIG_RST_LOOP_LSN  8'h28
`define PSIG_RST_LOOP_DET  8'hc8
`define PSIG_SLAVE_MIN     8'h01
`define PSIG_SLAVE_MAX     8'hf7
`define PSIG_RST_SLAVE     8'h01
`define PSIG_HOURS_STICKY  8'h63
`define PSIG_LOG_DEPTH     99

// ----------------------------------------------------------------------
// Screen codes
// ----------------------------------------------------------------------
`define PSIG_SCR_OFF       3'h0
`define PSIG_SCR_SPLASH    3'h1
`define PSIG_SCR_PRODUCT   3'h2
`define PSIG_SCR_CLOCK     3'h3
`define PSIG_SCR_BASELINE  3'h4
`define PSIG_SCR_APPROACH  3'h5
`define PSIG_SCR_DETECT    3'h6
`define PSIG_SCR_MENU      3'h7

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PSIG_CLK_PERIOD_NS 10
`define PSIG_TICK_NS       1000000000
`define PSIG_TICK_CYCLES   (`PSIG_TICK_NS / `PSIG_CLK_PERIOD_NS)
`define PSIG_FLASH_NS      100000000
`define PSIG_FLASH_CYCLES  (`PSIG_FLASH_NS / `PSIG_CLK_PERIOD_NS)
`define PSIG_SCREEN_S      3'h5
`define PSIG_LISTEN_FLASH_S 3'h5

`endif

// >>> psig_front_end.sv
// Front end model: baseline handshake and level difference.
// Assumes the bench raises hi_i for the length of a pig passage.
`timescale 1ns/1ps
`default_nettype none
module psig_front_end #(parameter DONE_DLY = 30) (
   // Clock and commands
   input  wire logic        clk_i,
   input  wire logic        start_i,
   input  wire logic        hi_i,
   // Toward the sequencer
   output logic             done_o,
   output logic [15:0]      diff_o
);
   int n = 0;
   // Baseline is slow on purpose, so the phase is really waited for
   always @(posedge clk_i)
      n <= start_i ? 1 : (n != 0 ? n + 1 : 0);
   assign done_o = (n == DONE_DLY);
   // Quiet level sits below the lower threshold, loud above the upper
   assign diff_o = hi_i ? 16'h0200 : 16'h0010;
endmodule
`default_nettype wire

// >>> psig_mode_seq.v
// Operating-mode sequencer: power-on screens, baseline phase, listening,
// approach and detection, LED cadence, relay and current-loop levels,
// event log, hold delay and button overrides.
// Assumes the front end delivers the level difference on this clock and
// the button arrives raw from a pin.
// How it works
// - Splash screen first, five-second countdown shown
// - Splash ends on countdown zero or press
// - Then product screen, then date-time screen
// - Date and time shown blank until set
// - Then baseline phase acquires ambient noise level
// - Listening: display off, flash every five seconds
// - Listening holds relay and loop non-detection
// - Button in listening enters the menu
// - Approach shown; cancel blanks, else detection
// - Detection: message, one-second flash, outputs set
// - Each detection timestamp stored for later viewing
// - Hold delay elapses, then back to listening
// - Button during detection ends hold at once
// - Hours 99 latches; button or serial clears
// - Loop levels configurable 4-20 mA, defaults
// - Log keeps at most 99 events
// - Approach cancelled unless excursion outlasted minimum time
// - Slave address accepted only 1 to 247
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/1ps
`include "psig_defines.vh"
`default_nettype none

module psig_mode_seq
#(
   parameter TICK_CYCLES  = `PSIG_TICK_CYCLES,
   parameter FLASH_CYCLES = `PSIG_FLASH_CYCLES,
   parameter DIFF_W       = 16,
   parameter FW_VERSION   = 32'h00010000   // Arbitrary value
)
(
   // Clock and reset
   input  wire              CLK_I,
   input  wire              SRST_I,
   // Register port
   input  wire [7:0]        ADDR_I,
   input  wire [31:0]       WDATA_I,
   input  wire              WR_I,
   input  wire              RD_I,
   output reg  [31:0]       RDATA_O,
   // Front end and button
   input  wire              BUTTON_I,
   input  wire [DIFF_W-1:0] LEVEL_DIFFERENCE_I,
   input  wire              BASELINE_DONE_I,
   input  wire              MENU_DONE_I,
   // Display
   output reg  [2:0]        SCREEN_O,
   output reg  [2:0]        SCREEN_TIMEOUT_COUNTER_O,
   output reg               TIME_BLANK_O,
   output reg  [31:0]       EVENT_TIME_O,
   // Front end control and menu
   output reg               BASELINE_START_O,
   output reg               MENU_ACTIVE_O,
   // Signalling outputs
   output reg               LED_O,
   output reg               RELAY_O,
   output reg  [7:0]        LOOP_LEVEL_O,
   output reg               IRQ_O
);

   // ----------------------------------------------------------------------
   // States
   // ----------------------------------------------------------------------
   localparam [7:0] S_SPLASH   = 8'h01;
   localparam [7:0] S_PRODUCT  = 8'h02;
   localparam [7:0] S_CLOCK    = 8'h04;
   localparam [7:0] S_BASELINE = 8'h08;
   localparam [7:0] S_LISTEN   = 8'h10;
   localparam [7:0] S_APPROACH = 8'h20;
   localparam [7:0] S_DETECT   = 8'h40;
   localparam [7:0] S_MENU     = 8'h80;

   reg  [7:0]        state_r;
   reg  [7:0]        state_nxt;
   reg  [2:0]        cd_r;
   reg  [2:0]        cd_nxt;
   reg  [19:0]       hold_r;
   reg  [19:0]       hold_nxt;
   reg               sticky_event_state_r;
   reg               sticky_nxt;
   reg  [7:0]        exc_r;
   reg  [7:0]        exc_nxt;
   reg  [2:0]        lflash_r;
   reg  [31:0]       flash_r;
   reg               btn_s1_r;
   reg               btn_s2_r;
   reg               btn_d_r;
   reg  [23:0]       hold_hours_field_r;
   reg  [DIFF_W-1:0] upper_trip_threshold_r;
   reg  [DIFF_W-1:0] lower_trip_threshold_r;
   reg  [7:0]        minimum_excursion_time_r;
   reg  [7:0]        loop_lsn_r;
   reg  [7:0]        loop_det_r;
   reg  [7:0]        slave_r;
   reg  [31:0]       time_r;
   reg               time_set_r;
   reg  [6:0]        ev_cnt_r;
   reg  [6:0]        ev_idx_r;
   reg  [31:0]       ev_mem [0:`PSIG_LOG_DEPTH-1];
   reg  [4:0]        irq_stat_r;
   reg  [4:0]        irq_mask_r;
   reg  [4:0]        irq_set;
   reg  [31:0]       rd_val;
   reg               log_evt;
   wire              tick;
   wire              press;
   wire              ser_reset;
   wire              log_full;

   // ----------------------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------------------
   // Hold delay field (hours, minutes, seconds) to a count of seconds
   function [19:0] hold_seconds;
      input [23:0] f;
      begin
         hold_seconds = ({12'h000, f[23:16]} * 20'h00e10)
                      + ({12'h000, f[15:8]} * 20'h0003c)
                      + {12'h000, f[7:0]};
      end
   endfunction

   // Inclusive range check used for every bounded setting
   function in_range;
      input [7:0] v;
      input [7:0] lo;
      input [7:0] hi;
      begin
         in_range = (v >= lo) && (v <= hi);
      end
   endfunction

   // ----------------------------------------------------------------------
   // Tick and button
   // ----------------------------------------------------------------------
   psig_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick
   (
      .clk_i  (CLK_I),
      .srst_i (SRST_I),
      .tick_o (tick)
   );

   // Button is a pin: two flops before the edge detector
   always @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         btn_s1_r <= 1'b0;
         btn_s2_r <= 1'b0;
         btn_d_r  <= 1'b0;
      end
      else
      begin
         btn_s1_r <= BUTTON_I;
         btn_s2_r <= btn_s1_r;
         btn_d_r  <= btn_s2_r;
      end
   end

   assign press     = btn_s2_r & ~btn_d_r;
   assign ser_reset = WR_I && (ADDR_I == `PSIG_OFF_CTRL) && WDATA_I[`PSIG_CTRL_DET_RST];
   assign log_full  = (ev_cnt_r == `PSIG_LOG_DEPTH);

   // ----------------------------------------------------------------------
   // Mode sequencer
   // ----------------------------------------------------------------------
   always @*
   begin
      state_nxt  = state_r;
      cd_nxt     = cd_r;
      hold_nxt   = hold_r;
      sticky_nxt = sticky_event_state_r;
      exc_nxt    = exc_r;
      log_evt    = 1'b0;
      irq_set    = 5'h00;
      case (state_r)
         S_SPLASH:
         begin
            if (press || (tick && cd_r == 3'h1))
            begin
               state_nxt = S_PRODUCT;
               cd_nxt    = `PSIG_SCREEN_S;
            end
            else if (tick)
               cd_nxt = cd_r - 3'h1;
         end
         S_PRODUCT, S_CLOCK:
         begin
            if (tick && cd_r == 3'h1)
            begin
               state_nxt = (state_r == S_PRODUCT) ? S_CLOCK : S_BASELINE;
               cd_nxt    = `PSIG_SCREEN_S;
            end
            else if (tick)
               cd_nxt = cd_r - 3'h1;
         end
         S_BASELINE:
         begin
            if (BASELINE_DONE_I)
            begin
               state_nxt = S_LISTEN;
               irq_set[`PSIG_IRQ_BASELINE] = 1'b1;
            end
         end
         S_LISTEN:
         begin
            if (press)
               state_nxt = S_MENU;
            else if (LEVEL_DIFFERENCE_I > upper_trip_threshold_r)
            begin
               state_nxt = S_APPROACH;
               exc_nxt   = 8'h00;
               irq_set[`PSIG_IRQ_APPROACH] = 1'b1;
            end
         end
         S_APPROACH:
         begin
            // Time above the upper threshold, saturating
            if (tick && LEVEL_DIFFERENCE_I > upper_trip_threshold_r && exc_r != 8'hff)
               exc_nxt = exc_r + 8'h01;
            if (LEVEL_DIFFERENCE_I < lower_trip_threshold_r)
            begin
               if (exc_r > minimum_excursion_time_r)
               begin
                  state_nxt  = S_DETECT;
                  log_evt    = 1'b1;
                  hold_nxt   = hold_seconds(hold_hours_field_r);
                  sticky_nxt = (hold_hours_field_r[23:16] == `PSIG_HOURS_STICKY);
                  irq_set[`PSIG_IRQ_DETECT]  = 1'b1;
                  irq_set[`PSIG_IRQ_LOGFULL] = log_full;
               end
               else
               begin
                  state_nxt = S_LISTEN;
                  irq_set[`PSIG_IRQ_CANCEL] = 1'b1;
               end
            end
         end
         S_DETECT:
         begin
            if (press || ser_reset)
            begin
               state_nxt  = S_LISTEN;
               sticky_nxt = 1'b0;
            end
            else if (!sticky_event_state_r && tick)
            begin
               if (hold_r <= 20'h00001)
                  state_nxt = S_LISTEN;
               else
                  hold_nxt = hold_r - 20'h00001;
            end
         end
         S_MENU:
         begin
            if (MENU_DONE_I)
               state_nxt = S_LISTEN;
         end
         default:
            state_nxt = S_SPLASH;
      endcase
   end

   always @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         state_r              <= S_SPLASH;
         cd_r                 <= `PSIG_SCREEN_S;
         hold_r               <= 20'h00000;
         sticky_event_state_r <= 1'b0;
         exc_r                <= 8'h00;
      end
      else
      begin
         state_r              <= state_nxt;
         cd_r                 <= cd_nxt;
         hold_r               <= hold_nxt;
         sticky_event_state_r <= sticky_nxt;
         exc_r                <= exc_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // Clock, event log and settings
   // ----------------------------------------------------------------------
   // Out-of-range writes leave the old setting, so a bad serial write
   // cannot push the loop or the slave address outside its span
   always @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         hold_hours_field_r       <= `PSIG_RST_HOLD;
         upper_trip_threshold_r   <= `PSIG_RST_UPPER;
         lower_trip_threshold_r   <= `PSIG_RST_LOWER;
         minimum_excursion_time_r <= `PSIG_RST_EXCUR;
         loop_lsn_r               <= `PSIG_RST_LOOP_LSN;
         loop_det_r               <= `PSIG_RST_LOOP_DET;
         slave_r                  <= `PSIG_RST_SLAVE;
         time_r                   <= 32'h00000000;
         time_set_r               <= 1'b0;
         ev_cnt_r                 <= 7'h00;
         ev_idx_r                 <= 7'h00;
         irq_mask_r               <= 5'h00;
      end
      else
      begin
         if (WR_I && ADDR_I == `PSIG_OFF_HOLD)
            hold_hours_field_r <= WDATA_I[23:0];
         if (WR_I && ADDR_I == `PSIG_OFF_UPPER)
            upper_trip_threshold_r <= WDATA_I[DIFF_W-1:0];
         if (WR_I && ADDR_I == `PSIG_OFF_LOWER)
            lower_trip_threshold_r <= WDATA_I[DIFF_W-1:0];
         if (WR_I && ADDR_I == `PSIG_OFF_EXCUR)
            minimum_excursion_time_r <= WDATA_I[7:0];
         if (WR_I && ADDR_I == `PSIG_OFF_LOOP)
         begin
            if (in_range(WDATA_I[7:0], `PSIG_LOOP_MIN, `PSIG_LOOP_MAX))
               loop_lsn_r <= WDATA_I[7:0];
            if (in_range(WDATA_I[15:8], `PSIG_LOOP_MIN, `PSIG_LOOP_MAX))
               loop_det_r <= WDATA_I[15:8];
         end
         if (WR_I && ADDR_I == `PSIG_OFF_SLAVE
             && in_range(WDATA_I[7:0], `PSIG_SLAVE_MIN, `PSIG_SLAVE_MAX))
            slave_r <= WDATA_I[7:0];
         // A write to the clock wins over the running second count
         if (WR_I && ADDR_I == `PSIG_OFF_TIME)
         begin
            time_r     <= WDATA_I;
            time_set_r <= 1'b1;
         end
         else if (tick)
            time_r <= time_r + 32'h00000001;
         if (WR_I && ADDR_I == `PSIG_OFF_EVIDX)
            ev_idx_r <= WDATA_I[6:0];
         if (WR_I && ADDR_I == `PSIG_OFF_IRQ_MASK)
            irq_mask_r <= WDATA_I[4:0];
         // Log stops when full rather than overwrite the oldest entry
         if (log_evt && !log_full)
            ev_cnt_r <= ev_cnt_r + 7'h01;
      end
   end

   // Log memory has no reset; entries beyond the count read as zero
   always @(posedge CLK_I)
   begin
      if (log_evt && !log_full)
         ev_mem[ev_cnt_r] <= time_r;
   end

   // ----------------------------------------------------------------------
   // Interrupts and read port
   // ----------------------------------------------------------------------
   // A new event in the clearing cycle stays set
   always @(posedge CLK_I)
   begin
      if (SRST_I)
         irq_stat_r <= 5'h00;
      else if (WR_I && ADDR_I == `PSIG_OFF_IRQ_STAT)
         irq_stat_r <= (irq_stat_r & ~WDATA_I[4:0]) | irq_set;
      else
         irq_stat_r <= irq_stat_r | irq_set;
   end

   always @*
   begin
      rd_val = 32'h00000000;
      case (ADDR_I)
         `PSIG_OFF_STATUS:   rd_val = {16'h0000, 7'h00, sticky_event_state_r, state_r};
         `PSIG_OFF_HOLD:     rd_val = {8'h00, hold_hours_field_r};
         `PSIG_OFF_UPPER:    rd_val[DIFF_W-1:0] = upper_trip_threshold_r;
         `PSIG_OFF_LOWER:    rd_val[DIFF_W-1:0] = lower_trip_threshold_r;
         `PSIG_OFF_EXCUR:    rd_val = {24'h000000, minimum_excursion_time_r};
         `PSIG_OFF_LOOP:     rd_val = {16'h0000, loop_det_r, loop_lsn_r};
         `PSIG_OFF_SLAVE:    rd_val = {24'h000000, slave_r};
         `PSIG_OFF_TIME:     rd_val = time_r;
         `PSIG_OFF_EVCNT:    rd_val = {25'h0000000, ev_cnt_r};
         `PSIG_OFF_EVIDX:    rd_val = {25'h0000000, ev_idx_r};
         `PSIG_OFF_EVDATA:
            if (ev_idx_r < ev_cnt_r)
               rd_val = ev_mem[ev_idx_r];
         `PSIG_OFF_IRQ_STAT: rd_val = {27'h0000000, irq_stat_r};
         `PSIG_OFF_IRQ_MASK: rd_val = {27'h0000000, irq_mask_r};
         `PSIG_OFF_VERSION:  rd_val = FW_VERSION;
         default:            rd_val = 32'h00000000;
      endcase
   end

   // Read data stand in each cycle after a cycle with the read strobe, zero otherwise
   always @(posedge CLK_I)
   begin
      if (SRST_I)
         RDATA_O <= 32'h00000000;
      else
         RDATA_O <= RD_I ? rd_val : 32'h00000000;
   end

   // ----------------------------------------------------------------------
   // LED cadence
   // ----------------------------------------------------------------------
   // Listening flashes every fifth tick, detection every tick
   always @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         lflash_r <= 3'h0;
         flash_r  <= 32'h00000000;
         LED_O    <= 1'b0;
      end
      else
      begin
         if (state_r != S_LISTEN)
            lflash_r <= 3'h0;
         else if (tick)
            lflash_r <= (lflash_r == `PSIG_LISTEN_FLASH_S - 3'h1) ? 3'h0 : lflash_r + 3'h1;
         if (tick && ((state_r == S_LISTEN && lflash_r == `PSIG_LISTEN_FLASH_S - 3'h1)
                      || state_r == S_DETECT))
         begin
            flash_r <= FLASH_CYCLES - 1;
            LED_O   <= 1'b1;
         end
         else if (flash_r != 32'h00000000)
            flash_r <= flash_r - 32'h00000001;
         else
            LED_O <= 1'b0;
      end
   end

   // ----------------------------------------------------------------------
   // Display, outputs and interrupt line
   // ----------------------------------------------------------------------
   always @(posedge CLK_I)
   begin
      if (SRST_I)
      begin
         SCREEN_O                 <= `PSIG_SCR_SPLASH;
         SCREEN_TIMEOUT_COUNTER_O <= `PSIG_SCREEN_S;
         TIME_BLANK_O             <= 1'b1;
         EVENT_TIME_O             <= 32'h00000000;
         BASELINE_START_O         <= 1'b0;
         MENU_ACTIVE_O            <= 1'b0;
         RELAY_O                  <= 1'b0;
         LOOP_LEVEL_O             <= `PSIG_RST_LOOP_LSN;
         IRQ_O                    <= 1'b0;
      end
      else
      begin
         case (state_r)
            S_SPLASH:   SCREEN_O <= `PSIG_SCR_SPLASH;
            S_PRODUCT:  SCREEN_O <= `PSIG_SCR_PRODUCT;
            S_CLOCK:    SCREEN_O <= `PSIG_SCR_CLOCK;
            S_BASELINE: SCREEN_O <= `PSIG_SCR_BASELINE;
            S_APPROACH: SCREEN_O <= `PSIG_SCR_APPROACH;
            S_DETECT:   SCREEN_O <= `PSIG_SCR_DETECT;
            S_MENU:     SCREEN_O <= `PSIG_SCR_MENU;
            default:    SCREEN_O <= `PSIG_SCR_OFF;
         endcase
         SCREEN_TIMEOUT_COUNTER_O <= cd_r;
         TIME_BLANK_O             <= ~time_set_r;
         if (log_evt)
            EVENT_TIME_O <= time_r;
         BASELINE_START_O <= (state_r == S_CLOCK) && (state_nxt == S_BASELINE);
         MENU_ACTIVE_O    <= (state_r == S_MENU);
         RELAY_O          <= (state_r == S_DETECT);
         LOOP_LEVEL_O     <= (state_r == S_DETECT) ? loop_det_r : loop_lsn_r;
         IRQ_O            <= |(irq_stat_r & irq_mask_r);
      end
   end

endmodule
`default_nettype wire

// >>> psig_tick.v
// One-second tick divider for the operating-mode sequencer.
// Assumes a free-running system clock and a synchronous active-high reset.
`timescale 1ns/1ps
`include "psig_defines.vh"
`default_nettype none

module psig_tick
#(
   parameter TICK_CYCLES = `PSIG_TICK_CYCLES
)
(
   // Clock and reset
   input  wire        clk_i,
   input  wire        srst_i,
   // Tick
   output reg         tick_o
);

   reg [31:0] div_r;

   // ----------------------------------------------------------------------
   // Divider
   // ----------------------------------------------------------------------
   // Counts down so the compare is against a constant zero
   always @(posedge clk_i)
   begin
      if (srst_i)
      begin
         div_r  <= 32'h00000000;
         tick_o <= 1'b0;
      end
      else if (div_r == 32'h00000000)
      begin
         div_r  <= TICK_CYCLES - 1;
         tick_o <= 1'b1;
      end
      else
      begin
         div_r  <= div_r - 32'h00000001;
         tick_o <= 1'b0;
      end
   end

endmodule
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the mode sequencer.
// Assumes a 20-cycle tick and a 4-cycle flash.
`timescale 1ns/1ps
`include "psig_defines.vh"
`default_nettype none
module tb_top;
   logic        CLK_I = 1'b0, SRST_I = 1'b1, WR_I = 1'b0, RD_I = 1'b0;
   logic        BUTTON_I = 1'b0, MENU_DONE_I = 1'b0, hi = 1'b0;
   logic        BASELINE_DONE_I, TIME_BLANK_O, BASELINE_START_O, MENU_ACTIVE_O;
   logic        LED_O, RELAY_O, IRQ_O;
   logic [7:0]  ADDR_I = 8'h00, LOOP_LEVEL_O;
   logic [31:0] WDATA_I = 32'h0, RDATA_O, EVENT_TIME_O;
   logic [15:0] LEVEL_DIFFERENCE_I;
   logic [2:0]  SCREEN_O, SCREEN_TIMEOUT_COUNTER_O;
   int          err_count = 0, checked = 0, cyc = 0;
   psig_mode_seq #(.TICK_CYCLES(20), .FLASH_CYCLES(4)) DUT (.*);
   psig_front_end u_fe (.clk_i(CLK_I), .start_i(BASELINE_START_O), .hi_i(hi),
      .done_o(BASELINE_DONE_I), .diff_o(LEVEL_DIFFERENCE_I));
   always #5 CLK_I = ~CLK_I;
   // -------------------------
   // Tasks
   // -------------------------
   task step(input int k);
      repeat (k) @(posedge CLK_I);
      #1;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e)
      begin
         err_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task stop_test;
      if (err_count == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   // Strobe drops a cycle before the next access, never in the same step
   task wr(input logic [7:0] a, input logic [31:0] d);
      ADDR_I <= a;
      WDATA_I <= d;
      WR_I <= 1'b1;
      step(1);
      WR_I <= 1'b0;
      step(1);
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      ADDR_I <= a;
      RD_I <= 1'b1;
      step(1);
      RD_I <= 1'b0;
      chk(RDATA_O, e);
   endtask
   task automatic ws(input logic [2:0] s, input int lim);
      int n = 0;
      while (SCREEN_O !== s && n < lim)
      begin
         step(1);
         n++;
      end
      chk(SCREEN_O, s);
   endtask
   task press;
      BUTTON_I <= 1'b1;
      step(4);
      BUTTON_I <= 1'b0;
   endtask
   // Rise-to-rise flash period, measured from a fall to the next rise
   task automatic gap(input int e);
      int n = 0;
      while (LED_O !== 1'b1) step(1);
      while (LED_O !== 1'b0) step(1);
      while (LED_O !== 1'b1 && n < 200)
      begin
         step(1);
         n++;
      end
      chk(n + 4, e);
   endtask
   task pig(input int len);
      hi <= 1'b1;
      ws(`PSIG_SCR_APPROACH, 10);
      step(len);
      hi <= 1'b0;
   endtask
   // -------------------------
   // Sequence
   // -------------------------
   always @(posedge CLK_I)
   begin
      cyc++;
      if (cyc == 6000)
      begin
         err_count++;
         stop_test;
      end
   end
   initial
   begin
      step(5);
      SRST_I <= 1'b0;
      step(1);
      chk(SCREEN_TIMEOUT_COUNTER_O, 3'h5);
      chk(LOOP_LEVEL_O, `PSIG_RST_LOOP_LSN);
      press;
      ws(`PSIG_SCR_PRODUCT, 10);
      ws(`PSIG_SCR_CLOCK, 130);
      chk(TIME_BLANK_O, 1'b1);
      ws(`PSIG_SCR_BASELINE, 130);
      ws(`PSIG_SCR_OFF, 60);
      gap(100);
      chk(LOOP_LEVEL_O, `PSIG_RST_LOOP_LSN);
      wr(`PSIG_OFF_TIME, 32'h100);
      chk(TIME_BLANK_O, 1'b0);
      press;
      ws(`PSIG_SCR_MENU, 10);
      chk(MENU_ACTIVE_O, 1'b1);
      MENU_DONE_I <= 1'b1;
      step(1);
      MENU_DONE_I <= 1'b0;
      ws(`PSIG_SCR_OFF, 10);
      wr(`PSIG_OFF_IRQ_MASK, 32'h1);
      pig(100);
      ws(`PSIG_SCR_DETECT, 10);
      chk(LOOP_LEVEL_O, `PSIG_RST_LOOP_DET);
      chk(IRQ_O, 1'b1);
      rd(`PSIG_OFF_EVCNT, 32'h1);
      wr(`PSIG_OFF_IRQ_STAT, 32'h1);
      chk(IRQ_O, 1'b0);
      gap(20);
      step(70);
      chk(SCREEN_O, `PSIG_SCR_DETECT);
      ws(`PSIG_SCR_OFF, 120);
      pig(2);
      ws(`PSIG_SCR_OFF, 10);
      rd(`PSIG_OFF_EVCNT, 32'h1);
      rd(8'h3c, 32'h0);
      wr(`PSIG_OFF_HOLD, 32'h00630000);
      pig(100);
      ws(`PSIG_SCR_DETECT, 10);
      step(300);
      chk(SCREEN_O, `PSIG_SCR_DETECT);
      gap(20);
      wr(`PSIG_OFF_CTRL, 32'h1);
      ws(`PSIG_SCR_OFF, 5);
      wr(`PSIG_OFF_HOLD, `PSIG_RST_HOLD);
      hi <= 1'b1;
      ws(`PSIG_SCR_APPROACH, 10);
      step(100);
      // Clock set one edge before the level drops, so the stamp is known
      ADDR_I <= `PSIG_OFF_TIME;
      WDATA_I <= 32'h200;
      WR_I <= 1'b1;
      step(1);
      WR_I <= 1'b0;
      hi <= 1'b0;
      step(2);
      ws(`PSIG_SCR_DETECT, 10);
      chk(EVENT_TIME_O, 32'h200);
      chk(RELAY_O, 1'b1);
      press;
      ws(`PSIG_SCR_OFF, 10);
      chk(RELAY_O, 1'b0);
      wr(`PSIG_OFF_EVIDX, 32'h2);
      rd(`PSIG_OFF_EVDATA, 32'h200);
      wr(`PSIG_OFF_LOOP, 32'h0000ff30);
      chk(LOOP_LEVEL_O, 8'h30);
      rd(`PSIG_OFF_LOOP, 32'h0000c830);
      wr(`PSIG_OFF_SLAVE, 32'hf8);
      rd(`PSIG_OFF_SLAVE, `PSIG_RST_SLAVE);
      wr(`PSIG_OFF_SLAVE, `PSIG_SLAVE_MAX);
      rd(`PSIG_OFF_SLAVE, `PSIG_SLAVE_MAX);
      stop_test;
   end
endmodule
`default_nettype wire
